/* bench/test_analog_front_end_control_regs.sv */
/*
 * Self-checking bench for the analog front end control register bank.
 * Assumes the bank is the only AHB-Lite slave, so hready loops back from hreadyout.
 */
`timescale 1ns/1ps
module test_analog_front_end_control_regs
    import afecr_pkg::*;
;
    logic        core_clk;       // 20 MHz clock
    logic        arst_n;         // Asynchronous reset
    logic        hsel;           // Slave select
    logic [31:0] haddr;          // Byte address
    logic [1:0]  htrans;         // Transfer type
    logic        hwrite;         // Write when high
    logic [2:0]  hsize;          // Always a word
    logic [31:0] hwdata;         // Write data
    logic [31:0] hrdata;         // Read data
    logic        hreadyout;      // Slave ready, also the bus ready
    logic        hresp;          // Response, checked to be zero
    logic        cmpOut;         // Raw comparator result
    afecr_comp_s compSel;        // Comparator selects
    afecr_pwr_s  pwrSel;         // Power selects
    logic        scanReset;      // Scan reset copy
    logic [5:0]  oscTrim;        // Trim copy
    logic [1:0]  prefilterSel;   // Pre-filter copy
    logic [3:0]  srcRefSel;      // Source reference copy
    logic        irq;            // Level interrupt
    int          numErrors;      // Mismatches seen
    int          samplesChecked; // Comparisons made

    afecr_top i_afecr_top (
        .core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cmpOut(cmpOut), .compSel(compSel), .pwrSel(pwrSel), .scanReset(scanReset),
        .oscTrim(oscTrim), .prefilterSel(prefilterSel), .srcRefSel(srcRefSel), .irq(irq)
    );

    // Free-running clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Verdict and end of run; also reached from any hang
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Compare with case inequality so unknowns never pass
    task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Wait for ready at a rising edge; a stuck slave ends the run
    task automatic waitReady();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                numErrors++;
                $display("wrong value at %0t: bus never ready", $time);
                test_done();
            end
            @(posedge core_clk);
        end
    endtask

    // One single AHB-Lite transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'b10;
        waitReady();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
        // Slave never signals an error
        check(40'(hresp), 40'h0, "bus response");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] dummy;
        bus(1'b1, {22'h0, idx, 2'b00}, {24'h0, d}, dummy);
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [31:0] d;
        bus(1'b0, {22'h0, idx, 2'b00}, 32'h0, d);
        check(40'(d), 40'(exp), what);
    endtask

    // Outputs follow a written register one edge after it lands
    task automatic settle();
        repeat (2) @(posedge core_clk);
    endtask

    // Everything cleared; regulator level and positive mux show their zero codes
    task automatic scenReset();
        localparam logic [7:0] REGS [8] = '{IDX_CMP_ONE, IDX_CMP_TWO, IDX_SCAN,
            IDX_PWR_REF, IDX_PUMP, IDX_REF_SW, IDX_IRQ_STAT, IDX_IRQ_MASK};
        afecr_pwr_s p;
        afecr_comp_s e;
        p = '0;
        p.ldoLevel = 4'h1;
        // Positive code zero still picks the internal 1.2V input
        e = '0;
        e.posMux = 6'h01;
        check(40'(compSel), 40'(e), "comparator selects at reset");
        check(40'(pwrSel), 40'(p), "power selects at reset");
        check(40'({scanReset, oscTrim, prefilterSel, srcRefSel, irq}), 40'h0, "copies");
        foreach (REGS[i]) rdChk(REGS[i], 8'h00, "register at reset");
    endtask

    // Every divider code, then every threshold in low-battery mode
    task automatic scenDivider();
        afecr_comp_s e;
        for (int c = 0; c < 8; c++) begin
            wr(IDX_CMP_TWO, {c[2], 7'h0});
            wr(IDX_CMP_ONE, {2'b00, c[1], c[0], 4'h5});
            settle();
            e = '0;
            e.divVdd = (c == 6);
            e.divLowBat = (c == 1);
            e.lowBatTap = (c == 1) ? 14'h0010 : 14'h0;
            e.posMux = 6'h01;
            e.negTap = (c == 6) ? 16'h0001 : 16'h0;
            check(40'(compSel), 40'(e), "divider decode");
        end
        // Last divider pass left bit two set; return to low-battery code
        wr(IDX_CMP_TWO, 8'h00);
        for (int t = 0; t < 16; t++) begin
            wr(IDX_CMP_ONE, {4'b0001, t[3:0]});
            settle();
            e = '0;
            e.divLowBat = 1'b1;
            e.lowBatTap = (t >= 1 && t <= 14) ? 14'(1 << (t - 1)) : 14'h0;
            e.extDetect = (t == 15);
            e.posMux = 6'h01;
            check(40'(compSel), 40'(e), "threshold decode");
        end
    endtask

    // Sixteen-step mode; each tap paired with a positive code, 6 and 7 select nothing
    task automatic scenMux();
        afecr_comp_s e;
        wr(IDX_CMP_ONE, 8'h20);
        for (int n = 0; n < 16; n++) begin
            // Positive code spans eight values, the most one scan key should use
            wr(IDX_CMP_TWO, {1'b1, n[2:0], n[3:0]});
            settle();
            e = '0;
            e.divVdd = 1'b1;
            e.posMux = (n[2:0] < 6) ? 6'(1 << n[2:0]) : 6'h0;
            e.negTap = 16'(1 << n);
            check(40'(compSel), 40'(e), "mux and tap decode");
        end
    endtask

    // All 256 values of the power and reference register
    task automatic scenPower();
        afecr_pwr_s p;
        for (int v = 0; v < 256; v++) begin
            wr(IDX_PWR_REF, v[7:0]);
            settle();
            p = '0;
            p.biasEnable = v[7];
            p.ldoEnable = v[2];
            p.ldoLevel = 4'h1 << v[1:0];
            p.agndEnable = (v[6:5] != 2'b00);
            p.agndLevel = (v[6:5] == 2'b00) ? 3'h0 : 3'(1 << (v[6:5] - 1));
            p.refGenEnable = v[4];
            p.bandgapOn = v[3];
            p.refBufOn = v[3] | v[2];
            check(40'(pwrSel), 40'(p), "power decode");
            rdChk(IDX_PWR_REF, v[7:0], "power readback");
        end
    endtask

    // Pump, switch and trim registers, including read-only-zero bits
    task automatic scenSwitch();
        logic [7:0] pat [4] = '{8'hFF, 8'h5A, 8'hA5, 8'h00};
        logic [31:0] junk; // Read data of dropped writes, ignored
        foreach (pat[i]) begin
            wr(IDX_PUMP, pat[i]);
            wr(IDX_REF_SW, pat[i]);
            wr(IDX_SCAN, pat[i]);
            settle();
            check(40'({pwrSel.pumpEnable, pwrSel.refFromPin, pwrSel.pinShort}),
                  40'({pat[i][6], pat[i][6], pat[i][7]}), "pump and switches");
            check(40'({prefilterSel, srcRefSel, scanReset, oscTrim}),
                  40'({pat[i][5:0], pat[i][7], pat[i][5:0]}), "copies");
            rdChk(IDX_PUMP, pat[i] & MASK_PUMP, "pump readback");
            rdChk(IDX_REF_SW, pat[i], "switch readback");
            rdChk(IDX_SCAN, pat[i] & MASK_SCAN, "trim readback");
        end
        bus(1'b1, 32'h0000_01C0, 32'h0000_00FF, junk);
        bus(1'b1, 32'h0000_04B4, 32'h0000_00FF, junk);
        rdChk(8'h70, 8'h00, "unmapped read");
        rdChk(IDX_CMP_ONE, 8'h20, "aliased write dropped");
    endtask

    // Event only while enabled; sticky flag, mask, clear by 0 and by 1
    task automatic scenComparator();
        int n;
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_CMP_ONE, 8'h00);
        cmpOut <= 1'b1;
        repeat (8) @(posedge core_clk);
        check(40'(irq), 40'h0, "no event while disabled");
        rdChk(IDX_CMP_ONE, 8'h00, "flag while disabled");
        cmpOut <= 1'b0;
        wr(IDX_CMP_ONE, 8'h80);
        settle();
        check(40'(compSel.enable), 40'h1, "comparator enable");
        cmpOut <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            n++;
        end
        check(40'(irq), 40'h1, "interrupt after event");
        // A missing event ends the run before the rest of the scenario
        if (irq !== 1'b1) begin
            test_done();
        end
        rdChk(IDX_CMP_ONE, 8'hC0, "event flag set");
        rdChk(IDX_IRQ_STAT, 8'h01, "status set");
        wr(IDX_IRQ_MASK, 8'h00);
        settle();
        check(40'(irq), 40'h0, "masked interrupt");
        wr(IDX_IRQ_MASK, 8'h01);
        settle();
        check(40'(irq), 40'h1, "unmasked interrupt");
        wr(IDX_CMP_ONE, 8'hC0);
        rdChk(IDX_CMP_ONE, 8'hC0, "flag kept by one");
        wr(IDX_CMP_ONE, 8'h80);
        rdChk(IDX_CMP_ONE, 8'h80, "flag cleared by zero");
        wr(IDX_IRQ_STAT, 8'h01);
        settle();
        check(40'(irq), 40'h0, "status cleared");
        rdChk(IDX_IRQ_STAT, 8'h00, "status reads clear");
        // Comparator input parked low, as a ladder pin driven low in sleep
        cmpOut <= 1'b0;
    endtask

    // Main sequence: reset for ten cycles, wait out the release flops
    initial begin
        numErrors = 0;
        samplesChecked = 0;
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        cmpOut = 1'b0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        scenReset();
        scenDivider();
        scenMux();
        scenPower();
        scenSwitch();
        scenComparator();
        test_done();
    end
endmodule

/* logic/afecr_top.sv */
/*
 * Analog front end control register bank with AHB-Lite slave.
 * Assumes an asynchronous comparator output and a single-master bus.
 */
`timescale 1ns/1ps
module afecr_top
    import afecr_pkg::*;
(
    input  wire logic        core_clk,  // 20 MHz system clock
    input  wire logic        arst_n,    // Asynchronous reset
    input  wire logic        hsel,      // Slave select
    input  wire logic [31:0] haddr,     // Byte address
    input  wire logic [1:0]  htrans,    // Transfer type
    input  wire logic        hwrite,    // Write when high
    input  wire logic [2:0]  hsize,     // Word only
    input  wire logic        hready,    // Bus ready
    input  wire logic [31:0] hwdata,    // Write data
    output logic      [31:0] hrdata,    // Read data
    output logic             hreadyout, // Slave ready
    output logic             hresp,     // Always OKAY
    input  wire logic        cmpOut,    // Raw comparator result
    output afecr_comp_s      compSel,   // Comparator selects
    output afecr_pwr_s       pwrSel,    // Power selects
    output logic             scanReset, // Scan reset bit
    output logic [5:0]       oscTrim,   // Oscillator trim
    output logic [1:0]       prefilterSel, // Pre-filter path
    output logic [3:0]       srcRefSel, // Reference source select
    output logic             irq        // Level interrupt
);
    logic [1:0]  rstPipe;     // Reset release stages
    logic        rstn;        // Synchronised reset
    logic        cmpMeta;     // First sync stage
    logic        cmpSync;     // Second sync stage
    logic        cmpLast;     // Previous synced value
    logic        cmpEvent;    // Rising comparator edge
    logic        evtFlag;     // Comparator event flag
    logic [7:0]  ctlOne;      // Comparator control one
    logic [7:0]  ctlTwo;      // Comparator control two
    logic [7:0]  scanTrim;    // Scan oscillator trim
    logic [7:0]  pwrRef;      // Power reference control
    logic [7:0]  pumpCtl;     // Charge pump control
    logic [7:0]  refSw;       // Reference switch control
    logic [7:0]  irqStat;     // Sticky interrupt status
    logic [7:0]  irqMask;     // Interrupt mask
    logic        wrPend;      // Write data phase pending
    logic        rdPend;      // Read data phase pending
    logic [7:0]  dpIdx;       // Latched register index
    logic        dpHit;       // Latched address mapped
    logic        addrTaken;   // Address phase accepted
    logic        wrNow;       // Write lands this cycle
    logic [7:0]  rdVal;       // Selected read value
    logic [2:0]  divCode;     // Divider source code
    logic [3:0]  thrCode;     // Threshold code
    logic [2:0]  posCode;     // Positive mux code
    afecr_comp_s next_comp;   // Decoded comparator lines
    afecr_pwr_s  next_pwr;    // Decoded power lines

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstn = rstPipe[1];

    // Comparator synchroniser; only the second stage is looked at
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmpMeta <= 1'b0;
            cmpSync <= 1'b0;
            cmpLast <= 1'b0;
        end else begin
            cmpMeta <= cmpOut;
            cmpSync <= cmpMeta;
            cmpLast <= cmpSync;
        end
    end
    // A reaction is a rising edge of the synced result
    assign cmpEvent = cmpSync & ~cmpLast & ctlOne[B_CMP_EN];

    // Bus address phase capture
    assign addrTaken = hsel & htrans[1] & hready;
    assign wrNow     = wrPend & dpHit;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            dpIdx  <= 8'h00;
            dpHit  <= 1'b0;
        end else if (hready) begin
            // New phase only when the bus moves on
            wrPend <= addrTaken & hwrite;
            rdPend <= addrTaken & ~hwrite;
            dpIdx  <= haddr[9:2];
            dpHit  <= (haddr[31:10] == 22'h0);
        end else if (hreadyout) begin
            rdPend <= 1'b0;
        end
    end

    // Reads take one wait state so hrdata comes from a flop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else if (addrTaken & ~hwrite) begin
            hreadyout <= 1'b0;
        end else if (rdPend & ~hreadyout) begin
            hreadyout <= 1'b1;
            hrdata    <= {24'h00_0000, rdVal};
        end
    end

    // Read mux; unmapped words read as zero
    always_comb begin
        rdVal = 8'h00;
        if (dpHit) begin
            case (dpIdx)
                IDX_CMP_ONE: begin
                    rdVal = ctlOne;
                    rdVal[B_CMP_FLAG] = evtFlag;
                end
                IDX_CMP_TWO:  rdVal = ctlTwo;
                IDX_SCAN:     rdVal = scanTrim;
                IDX_PWR_REF:  rdVal = pwrRef;
                IDX_PUMP:     rdVal = pumpCtl;
                IDX_REF_SW:   rdVal = refSw;
                IDX_IRQ_STAT: rdVal = irqStat;
                IDX_IRQ_MASK: rdVal = irqMask;
                default:      rdVal = 8'h00;
            endcase
        end
    end

    // Software control registers, all cleared at reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctlOne   <= REG_RST;
            ctlTwo   <= REG_RST;
            scanTrim <= REG_RST;
            pwrRef   <= REG_RST;
            pumpCtl  <= REG_RST;
            refSw    <= REG_RST;
            irqMask  <= REG_RST;
        end else if (wrNow) begin
            case (dpIdx)
                IDX_CMP_ONE:  ctlOne   <= hwdata[7:0];
                IDX_CMP_TWO:  ctlTwo   <= hwdata[7:0];
                IDX_SCAN:     scanTrim <= hwdata[7:0] & MASK_SCAN;
                IDX_PWR_REF:  pwrRef   <= hwdata[7:0] & MASK_PWR;
                IDX_PUMP:     pumpCtl  <= hwdata[7:0] & MASK_PUMP;
                IDX_REF_SW:   refSw    <= hwdata[7:0];
                IDX_IRQ_MASK: irqMask  <= hwdata[7:0] & MASK_IRQ;
                default: begin
                    // Writes outside the map are dropped
                end
            endcase
        end
    end

    // Event flag: set wins over a clearing write of zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            evtFlag <= 1'b0;
        end else if (cmpEvent) begin
            evtFlag <= 1'b1;
        end else if (wrNow && dpIdx == IDX_CMP_ONE && !hwdata[B_CMP_FLAG]) begin
            evtFlag <= 1'b0;
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irqStat <= REG_RST;
        end else begin
            if (wrNow && dpIdx == IDX_IRQ_STAT) begin
                irqStat <= irqStat & ~hwdata[7:0];
            end
            if (cmpEvent) begin
                irqStat[B_IRQ_CMP] <= 1'b1;
            end
        end
    end

    // Interrupt output straight from a flop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat & irqMask);
        end
    end

    // Field extraction
    assign divCode = {ctlTwo[B_DIV_TWO], ctlOne[B_DIV_ONE], ctlOne[B_DIV_ZERO]};
    assign thrCode = ctlOne[3:0];
    assign posCode = ctlTwo[B_POS_LO +: 3];

    // Decode of mode fields into select lines
    always_comb begin
        next_comp = '0;
        next_pwr  = '0;
        next_comp.enable    = ctlOne[B_CMP_EN];
        next_comp.divVdd    = (divCode == DIV_VDD);
        next_comp.divLowBat = (divCode == DIV_LOWBAT);
        // Threshold only matters in low-battery mode
        if (next_comp.divLowBat) begin
            if (thrCode == THR_EXT) begin
                next_comp.extDetect = 1'b1;
            end else if (thrCode != THR_OFF) begin
                next_comp.lowBatTap[thrCode - 4'h1] = 1'b1;
            end
        end
        // Codes above common-mode select nothing
        if (posCode < 3'(POS_CODES)) begin
            next_comp.posMux[posCode] = 1'b1;
        end
        // Tap n is (16-n)/16 of the supply
        if (next_comp.divVdd) begin
            next_comp.negTap[ctlTwo[3:0]] = 1'b1;
        end
        next_pwr.biasEnable   = pwrRef[B_BIAS];
        next_pwr.ldoEnable    = pwrRef[B_LDO_EN];
        next_pwr.ldoLevel[pwrRef[1:0]] = 1'b1;
        next_pwr.pumpEnable   = pumpCtl[B_PUMP];
        // Zero leaves the ground pin floating
        case (pwrRef[B_ANALOG_GROUND_LO +: 2])
            2'h1:    next_pwr.agndLevel = 3'h1;
            2'h2:    next_pwr.agndLevel = 3'h2;
            2'h3:    next_pwr.agndLevel = 3'h4;
            default: next_pwr.agndLevel = 3'h0;
        endcase
        next_pwr.agndEnable   = |pwrRef[B_ANALOG_GROUND_LO +: 2];
        next_pwr.refGenEnable = pwrRef[B_REFGEN];
        next_pwr.bandgapOn    = pwrRef[B_REFOUT];
        // Regulator enable drags the buffer on too
        next_pwr.refBufOn     = pwrRef[B_REFOUT] | pwrRef[B_LDO_EN];
        next_pwr.refFromPin   = refSw[B_REF_SRC];
        next_pwr.pinShort     = refSw[B_SHORT];
    end

    // Registered outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            compSel      <= '0;
            pwrSel       <= '0;
            scanReset    <= 1'b0;
            oscTrim      <= 6'h00;
            prefilterSel <= 2'h0;
            srcRefSel    <= 4'h0;
        end else begin
            compSel      <= next_comp;
            pwrSel       <= next_pwr;
            scanReset    <= scanTrim[B_SCAN_RST];
            oscTrim      <= scanTrim[5:0];
            prefilterSel <= refSw[B_PFILT_LO +: 2];
            srcRefSel    <= refSw[3:0];
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_cmp_enable: assert property (##1 compSel.enable == $past(ctlOne[B_CMP_EN]))
        else $error("comparator enable does not follow bit");
    a_event_flag: assert property (cmpEvent |=> evtFlag)
        else $error("comparator event lost");
    a_flag_clear: assert property (
        (wrNow && dpIdx == IDX_CMP_ONE && !hwdata[B_CMP_FLAG] && !cmpEvent) |=> !evtFlag)
        else $error("event flag not cleared by zero write");
    a_div_decode: assert property (compSel.divVdd |-> $past(divCode) == DIV_VDD)
        else $error("divider mode decoded wrongly");
    a_thr_mode: assert property (
        (compSel.lowBatTap != 14'h0 || compSel.extDetect) |-> compSel.divLowBat)
        else $error("threshold active outside low-battery mode");
    a_pos_onehot: assert property ($onehot0(compSel.posMux))
        else $error("positive mux not one-hot");
    a_neg_tap: assert property (compSel.negTap != 16'h0 |-> compSel.divVdd)
        else $error("negative tap outside divider mode");
    a_ldo_buffer: assert property (pwrSel.ldoEnable |-> pwrSel.refBufOn)
        else $error("buffer off while regulator on");
    a_ldo_level: assert property ($onehot(pwrSel.ldoLevel) || $past(!rstn))
        else $error("regulator level not one-hot");
    a_pump_follow: assert property ($rose(pumpCtl[B_PUMP]) |=> pwrSel.pumpEnable)
        else $error("pump enable late");
    a_analog_ground_float: assert property (!pwrSel.agndEnable |-> pwrSel.agndLevel == 3'h0)
        else $error("ground level selected while off");
    a_read_wait: assert property ((addrTaken && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read answer timing wrong");

    c_event: cover property (cmpEvent ##1 irq);
    c_read:  cover property (rdPend && hreadyout);
    c_write: cover property (wrNow && dpIdx == IDX_PWR_REF);
endmodule

/* pkg/afecr_pkg.sv */
/*
 * Constants and carrier types for the analog front end control bank.
 * Assumes a 32-bit AHB-Lite bus, one register per aligned word.
 */
package afecr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CMP_ONE  = 8'h2D;
    localparam logic [7:0] IDX_CMP_TWO  = 8'h2E;
    localparam logic [7:0] IDX_SCAN     = 8'h2F;
    localparam logic [7:0] IDX_PWR_REF  = 8'h5B;
    localparam logic [7:0] IDX_PUMP     = 8'h5C;
    localparam logic [7:0] IDX_REF_SW   = 8'h5D;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h60;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h61;

    // Field positions
    localparam int B_CMP_EN   = 7;
    localparam int B_CMP_FLAG = 6;
    localparam int B_DIV_ONE  = 5;
    localparam int B_DIV_ZERO = 4;
    localparam int B_DIV_TWO  = 7;
    localparam int B_POS_LO   = 4;
    localparam int B_BIAS     = 7;
    localparam int B_ANALOG_GROUND_LO  = 5;
    localparam int B_REFGEN   = 4;
    localparam int B_REFOUT   = 3;
    localparam int B_LDO_EN   = 2;
    localparam int B_PUMP     = 6;
    localparam int B_SHORT    = 7;
    localparam int B_REF_SRC  = 6;
    localparam int B_PFILT_LO = 4;
    localparam int B_SCAN_RST = 7;
    localparam int B_IRQ_CMP  = 0;

    // Writable bit masks and reset value
    localparam logic [7:0] MASK_SCAN = 8'hBF;
    localparam logic [7:0] MASK_PWR  = 8'hFF;
    localparam logic [7:0] MASK_PUMP = 8'hC0;
    localparam logic [7:0] MASK_IRQ  = 8'h01;
    localparam logic [7:0] REG_RST   = 8'h00;

    // Divider source codes
    localparam logic [2:0] DIV_VDD = 3'b110;
    localparam logic [2:0] DIV_LOWBAT = 3'b001;
    // Threshold codes and number of positive mux codes
    localparam logic [3:0] THR_OFF = 4'h0;
    localparam logic [3:0] THR_EXT = 4'hF;
    localparam int POS_CODES  = 6;

    // Comparator select lines
    typedef struct packed {
        logic        enable;      // Comparator active
        logic        divVdd;      // Sixteen-step divider mode
        logic        divLowBat;   // Low-battery mode
        logic [13:0] lowBatTap;   // One-hot divider taps
        logic        extDetect;   // External detect input routed
        logic [5:0]  posMux;      // One-hot positive input
        logic [15:0] negTap;      // One-hot negative tap
    } afecr_comp_s;

    // Power and reference select lines
    typedef struct packed {
        logic       biasEnable;   // Analog bias current
        logic       ldoEnable;    // Analog supply regulator
        logic [3:0] ldoLevel;     // 3.6, 3.2, 2.8, 2.4 V one-hot
        logic       pumpEnable;   // Charge pump regulator
        logic       agndEnable;   // Ground generator on
        logic [2:0] agndLevel;    // 0.3, 0.1, 0.5 of supply
        logic       refGenEnable; // Reference generator
        logic       bandgapOn;    // Internal bandgap
        logic       refBufOn;     // Reference output buffer
        logic       refFromPin;   // Buffer fed from port B pin 4
        logic       pinShort;     // Port B pins 0 and 2 shorted
    } afecr_pwr_s;
endpackage
